// file: logic/cfd_diag_pkg.sv
// package: register map, field layout and carrier types of the can fd diagnostics block
`default_nettype none
package cfd_diag_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CNT_DATA = 8'h00;
  localparam logic [7:0] OFS_CNT_NOM = 8'h04;
  localparam logic [7:0] OFS_ERR_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CLEAN_CNT = 8'h0c;
  localparam logic [7:0] OFS_STEER_UPPER = 8'h10;
  localparam logic [7:0] OFS_STEER_LOWER = 8'h14;

  // register select codes
  localparam logic [2:0] SEL_CNT_DATA = 3'h0;
  localparam logic [2:0] SEL_CNT_NOM = 3'h1;
  localparam logic [2:0] SEL_ERR_FLAGS = 3'h2;
  localparam logic [2:0] SEL_CLEAN_CNT = 3'h3;
  localparam logic [2:0] SEL_STEER_UPPER = 3'h4;
  localparam logic [2:0] SEL_STEER_LOWER = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ==========================================================
  // reset values and field masks
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [15:0] FLAG_IMPL_MASK = 16'hfbbf;
  localparam logic [15:0] FLAG_CLR_ONLY_MASK = 16'h2000;
  localparam logic [15:0] FLAG_RW_MASK = 16'hdbbf;
  localparam logic [7:0] SLOT_IMPL_MASK = 8'h9f;
  localparam int SLOT_EN_BIT = 7;

  // error flag bit positions
  localparam int FB_LEN_OVF = 15;
  localparam int FB_ESI = 14;
  localparam int FB_F_CRC = 13;
  localparam int FB_F_STUFF = 12;
  localparam int FB_F_FORM = 11;
  localparam int FB_F_BIT1 = 9;
  localparam int FB_F_BIT0 = 8;
  localparam int FB_BUS_OFF = 7;
  localparam int FB_S_CRC = 5;
  localparam int FB_S_STUFF = 4;
  localparam int FB_S_FORM = 3;
  localparam int FB_S_ACK = 2;
  localparam int FB_S_BIT1 = 1;
  localparam int FB_S_BIT0 = 0;

  // ==========================================================
  // protocol constants
  localparam logic [2:0] STUFF_RUN_LIMIT = 3'h5;
  localparam logic [3:0] RECOVERY_RUN = 4'hb;
  localparam logic [4:0] OBJ_PTR_MIN = 5'h01;
  localparam logic [4:0] OBJ_PTR_MAX = 5'h07;
  localparam logic [7:0] CNT8_MAX = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carrier types from the protocol engine
  typedef struct packed {
    logic fast_tx_err;
    logic fast_rx_err;
    logic slow_tx_err;
    logic slow_rx_err;
    logic form_err;
    logic form_fast;
    logic ack_err;
    logic esi_seen;
    logic bus_off_enter;
    logic frame_clean;
  } cfd_evt_t;

  typedef struct packed {
    logic chk;
    logic fast;
    logic [20:0] calc;
    logic [20:0] recv;
  } cfd_crc_t;

  typedef struct packed {
    logic chk;
    logic [3:0] dlc;
    logic [2:0] payload_cap;
  } cfd_dlc_t;

  typedef struct packed {
    logic valid;
    logic fast;
    logic tx_active;
    logic tx_level;
    logic bus_level;
    logic arbitration;
    logic stuff_zone;
    logic drive_zone;
    logic recovering;
  } cfd_bit_t;

  typedef struct packed {
    logic valid;
    logic [1:0] slot;
  } cfd_hit_t;

endpackage : cfd_diag_pkg
`default_nettype wire

// file: logic/cfd_diag.sv
// can fd bus diagnostics, error flags and receive steering behind an axi4-lite slave
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none

// Functional notes
// - data-phase transmit error count, upper byte
// - data-phase receive error count, lower byte
// - nominal transmit error count, upper byte
// - nominal receive error count, lower byte
// - flag when dlc exceeds buffer payload size
// - flag received fd frame with esi set
// - data-phase crc/stuff/form/bit flags; crc clear-only
// - flag every bus-off entry
// - flag crc mismatch on received message
// - flag more than five equal stuffed bits
// - flag illegal fixed-format field
// - flag transmitted frame never acknowledged
// - flag recessive sent, dominant seen, outside arbitration
// - flag dominant sent, recessive seen while driving
// - recovery: eleven recessive bits set dominant flag
// - 16-bit clean message counter, software writable
// - per-filter enable bit on top of slot
// - hit steers to object named by pointer
// - pointer zero reserved, never steered to
// - unimplemented bits ignore writes, read zero
module cfd_diag (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cfd_diag_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [cfd_diag_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // protocol engine events, same clock
  input wire cfd_diag_pkg::cfd_evt_t evt,
  input wire cfd_diag_pkg::cfd_crc_t crc,
  input wire cfd_diag_pkg::cfd_dlc_t dlc,
  input wire cfd_diag_pkg::cfd_bit_t bit_mon,
  input wire cfd_diag_pkg::cfd_hit_t hit,
  // steering result toward the receive buffers
  output logic steer_valid,
  output logic [4:0] steer_object
);

  // ==========================================================
  // state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [cfd_diag_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] fast_phase_tx_fault_count;
    logic [7:0] fast_phase_rx_fault_count;
    logic [7:0] slow_phase_tx_fault_count;
    logic [7:0] slow_phase_rx_fault_count;
    logic [15:0] flags;
    logic [15:0] clean_frame_counter;
    logic [15:0] steer_upper;
    logic [15:0] steer_lower;
    logic run_level;
    logic [2:0] run_len;
    logic [3:0] rec_len;
    logic steer_valid;
    logic [4:0] steer_object;
  } cfd_state_t;

  cfd_state_t s_r;
  cfd_state_t s_nxt;

  // ==========================================================
  // helpers
  function automatic logic [2:0] cfd_sel(input logic [cfd_diag_pkg::ADDR_W-1:0] a);
    case (a)
      cfd_diag_pkg::OFS_CNT_DATA: cfd_sel = cfd_diag_pkg::SEL_CNT_DATA;
      cfd_diag_pkg::OFS_CNT_NOM: cfd_sel = cfd_diag_pkg::SEL_CNT_NOM;
      cfd_diag_pkg::OFS_ERR_FLAGS: cfd_sel = cfd_diag_pkg::SEL_ERR_FLAGS;
      cfd_diag_pkg::OFS_CLEAN_CNT: cfd_sel = cfd_diag_pkg::SEL_CLEAN_CNT;
      cfd_diag_pkg::OFS_STEER_UPPER: cfd_sel = cfd_diag_pkg::SEL_STEER_UPPER;
      cfd_diag_pkg::OFS_STEER_LOWER: cfd_sel = cfd_diag_pkg::SEL_STEER_LOWER;
      default: cfd_sel = cfd_diag_pkg::SEL_NONE;
    endcase
  endfunction : cfd_sel

  // byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are ignored
  function automatic logic [15:0] cfd_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] st);
    cfd_merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : cfd_merge

  // error counters stop at the top instead of wrapping to a clean-looking zero
  function automatic logic [7:0] cfd_sat_inc(input logic [7:0] c, input logic inc);
    cfd_sat_inc = (inc && c != cfd_diag_pkg::CNT8_MAX) ? c + 8'h01 : c;
  endfunction : cfd_sat_inc

  function automatic logic [6:0] cfd_dlc_bytes(input logic [3:0] d);
    case (d)
      4'h9: cfd_dlc_bytes = 7'h0c;
      4'ha: cfd_dlc_bytes = 7'h10;
      4'hb: cfd_dlc_bytes = 7'h14;
      4'hc: cfd_dlc_bytes = 7'h18;
      4'hd: cfd_dlc_bytes = 7'h20;
      4'he: cfd_dlc_bytes = 7'h30;
      4'hf: cfd_dlc_bytes = 7'h40;
      default: cfd_dlc_bytes = {3'h0, d};
    endcase
  endfunction : cfd_dlc_bytes

  function automatic logic [6:0] cfd_cap_bytes(input logic [2:0] p);
    case (p)
      3'h0: cfd_cap_bytes = 7'h08;
      3'h1: cfd_cap_bytes = 7'h0c;
      3'h2: cfd_cap_bytes = 7'h10;
      3'h3: cfd_cap_bytes = 7'h14;
      3'h4: cfd_cap_bytes = 7'h18;
      3'h5: cfd_cap_bytes = 7'h20;
      3'h6: cfd_cap_bytes = 7'h30;
      default: cfd_cap_bytes = 7'h40;
    endcase
  endfunction : cfd_cap_bytes

  // ==========================================================
  // next state
  always_comb begin
    logic [15:0] set;
    logic [15:0] wv;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic do_wr;
    logic bit1_err;
    logic bit0_err;
    logic stuff_err;
    logic rec_hit;
    logic [7:0] slot;
    set = 16'h0000;
    wv = 16'h0000;
    wsel = cfd_sel(s_r.waddr);
    rsel = cfd_sel(s_axi_araddr);
    do_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    bit1_err = 1'b0;
    bit0_err = 1'b0;
    stuff_err = 1'b0;
    rec_hit = 1'b0;
    slot = 8'h00;
    s_nxt = s_r;

    // bus bit monitor
    if (bit_mon.valid) begin
      bit1_err = bit_mon.tx_active && !bit_mon.arbitration &&
                 bit_mon.tx_level && !bit_mon.bus_level;
      bit0_err = bit_mon.drive_zone && !bit_mon.tx_level && bit_mon.bus_level;
      if (bit_mon.stuff_zone) begin
        if (s_r.run_len != 3'h0 && bit_mon.bus_level == s_r.run_level) begin
          if (s_r.run_len == cfd_diag_pkg::STUFF_RUN_LIMIT) begin
            stuff_err = 1'b1;
            s_nxt.run_len = 3'h0;
          end else begin
            s_nxt.run_len = s_r.run_len + 3'h1;
          end
        end else begin
          s_nxt.run_len = 3'h1;
        end
        s_nxt.run_level = bit_mon.bus_level;
      end else begin
        s_nxt.run_len = 3'h0;
      end
      // recovery progress: restart the count on every dominant bit
      if (bit_mon.recovering && bit_mon.bus_level) begin
        if (s_r.rec_len == cfd_diag_pkg::RECOVERY_RUN - 4'h1) begin
          rec_hit = 1'b1;
          s_nxt.rec_len = 4'h0;
        end else begin
          s_nxt.rec_len = s_r.rec_len + 4'h1;
        end
      end else begin
        s_nxt.rec_len = 4'h0;
      end
    end

    // hardware flag sets
    set[cfd_diag_pkg::FB_LEN_OVF] = dlc.chk &&
        (cfd_dlc_bytes(dlc.dlc) > cfd_cap_bytes(dlc.payload_cap));
    set[cfd_diag_pkg::FB_ESI] = evt.esi_seen;
    set[cfd_diag_pkg::FB_F_CRC] = crc.chk && crc.fast && crc.calc != crc.recv;
    set[cfd_diag_pkg::FB_F_STUFF] = stuff_err && bit_mon.fast;
    set[cfd_diag_pkg::FB_F_FORM] = evt.form_err && evt.form_fast;
    set[cfd_diag_pkg::FB_F_BIT1] = bit1_err && bit_mon.fast;
    set[cfd_diag_pkg::FB_F_BIT0] = bit0_err && bit_mon.fast;
    set[cfd_diag_pkg::FB_BUS_OFF] = evt.bus_off_enter;
    set[cfd_diag_pkg::FB_S_CRC] = crc.chk && !crc.fast && crc.calc != crc.recv;
    set[cfd_diag_pkg::FB_S_STUFF] = stuff_err && !bit_mon.fast;
    set[cfd_diag_pkg::FB_S_FORM] = evt.form_err && !evt.form_fast;
    set[cfd_diag_pkg::FB_S_ACK] = evt.ack_err;
    set[cfd_diag_pkg::FB_S_BIT1] = bit1_err && !bit_mon.fast;
    set[cfd_diag_pkg::FB_S_BIT0] = (bit0_err && !bit_mon.fast) || rec_hit;

    // counters: a software write in the same cycle wins over an increment
    s_nxt.fast_phase_tx_fault_count = cfd_sat_inc(s_r.fast_phase_tx_fault_count,
                                                  evt.fast_tx_err);
    s_nxt.fast_phase_rx_fault_count = cfd_sat_inc(s_r.fast_phase_rx_fault_count,
                                                  evt.fast_rx_err);
    s_nxt.slow_phase_tx_fault_count = cfd_sat_inc(s_r.slow_phase_tx_fault_count,
                                                  evt.slow_tx_err);
    s_nxt.slow_phase_rx_fault_count = cfd_sat_inc(s_r.slow_phase_rx_fault_count,
                                                  evt.slow_rx_err);
    s_nxt.clean_frame_counter = s_r.clean_frame_counter +
                                {15'h0000, evt.frame_clean};
    s_nxt.flags = s_r.flags;

    // ========================================================
    // axi write channel
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wsel == cfd_diag_pkg::SEL_NONE) ? cfd_diag_pkg::RESP_SLVERR
                                                     : cfd_diag_pkg::RESP_OKAY;
      case (wsel)
        cfd_diag_pkg::SEL_CNT_DATA: begin
          wv = cfd_merge({s_r.fast_phase_tx_fault_count, s_r.fast_phase_rx_fault_count},
                         s_r.wdata, s_r.wstrb);
          s_nxt.fast_phase_tx_fault_count = wv[15:8];
          s_nxt.fast_phase_rx_fault_count = wv[7:0];
        end
        cfd_diag_pkg::SEL_CNT_NOM: begin
          wv = cfd_merge({s_r.slow_phase_tx_fault_count, s_r.slow_phase_rx_fault_count},
                         s_r.wdata, s_r.wstrb);
          s_nxt.slow_phase_tx_fault_count = wv[15:8];
          s_nxt.slow_phase_rx_fault_count = wv[7:0];
        end
        cfd_diag_pkg::SEL_ERR_FLAGS: begin
          // the data-phase crc flag can only be cleared, never set, by software
          wv = cfd_merge(s_r.flags, s_r.wdata, s_r.wstrb);
          s_nxt.flags = (wv & cfd_diag_pkg::FLAG_RW_MASK) |
                        (wv & s_r.flags & cfd_diag_pkg::FLAG_CLR_ONLY_MASK);
        end
        cfd_diag_pkg::SEL_CLEAN_CNT: begin
          s_nxt.clean_frame_counter = cfd_merge(s_r.clean_frame_counter,
                                                s_r.wdata, s_r.wstrb);
        end
        cfd_diag_pkg::SEL_STEER_UPPER: begin
          wv = cfd_merge(s_r.steer_upper, s_r.wdata, s_r.wstrb);
          s_nxt.steer_upper = wv & {cfd_diag_pkg::SLOT_IMPL_MASK,
                                    cfd_diag_pkg::SLOT_IMPL_MASK};
        end
        cfd_diag_pkg::SEL_STEER_LOWER: begin
          wv = cfd_merge(s_r.steer_lower, s_r.wdata, s_r.wstrb);
          s_nxt.steer_lower = wv & {cfd_diag_pkg::SLOT_IMPL_MASK,
                                    cfd_diag_pkg::SLOT_IMPL_MASK};
        end
        default: begin
        end
      endcase
    end
    // sets land after the software write so a same-cycle clear loses
    s_nxt.flags = (s_nxt.flags | set) & cfd_diag_pkg::FLAG_IMPL_MASK;
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

    // ========================================================
    // axi read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = cfd_diag_pkg::RESP_OKAY;
      case (rsel)
        cfd_diag_pkg::SEL_CNT_DATA: s_nxt.rdata = {16'h0000, s_r.fast_phase_tx_fault_count,
                                                   s_r.fast_phase_rx_fault_count};
        cfd_diag_pkg::SEL_CNT_NOM: s_nxt.rdata = {16'h0000, s_r.slow_phase_tx_fault_count,
                                                  s_r.slow_phase_rx_fault_count};
        cfd_diag_pkg::SEL_ERR_FLAGS: s_nxt.rdata = {16'h0000, s_r.flags};
        cfd_diag_pkg::SEL_CLEAN_CNT: s_nxt.rdata = {16'h0000, s_r.clean_frame_counter};
        cfd_diag_pkg::SEL_STEER_UPPER: s_nxt.rdata = {16'h0000, s_r.steer_upper};
        cfd_diag_pkg::SEL_STEER_LOWER: s_nxt.rdata = {16'h0000, s_r.steer_lower};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = cfd_diag_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // ========================================================
    // receive steering
    case (hit.slot)
      2'h0: slot = s_r.steer_lower[7:0];
      2'h1: slot = s_r.steer_lower[15:8];
      2'h2: slot = s_r.steer_upper[7:0];
      default: slot = s_r.steer_upper[15:8];
    endcase
    // reserved pointers, zero included, are dropped rather than steered anywhere
    s_nxt.steer_valid = hit.valid && slot[cfd_diag_pkg::SLOT_EN_BIT] &&
                        slot[4:0] >= cfd_diag_pkg::OBJ_PTR_MIN &&
                        slot[4:0] <= cfd_diag_pkg::OBJ_PTR_MAX;
    s_nxt.steer_object = s_nxt.steer_valid ? slot[4:0] : 5'h00;
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign steer_valid = s_r.steer_valid;
  assign steer_object = s_r.steer_object;

endmodule : cfd_diag
`default_nettype wire

// file: verification/cfd_diag_chk.sv
// checker: port-level properties of the can fd diagnostics block
`default_nettype none
module cfd_diag_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // steering
  input wire cfd_diag_pkg::cfd_hit_t hit,
  input wire logic steer_valid,
  input wire logic [4:0] steer_object
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ====
  // steering
  a_steer_cause: assert property (steer_valid |-> $past(hit.valid))
    else $error("steer without hit");
  a_steer_range: assert property (steer_valid |-> steer_object inside {[5'h01:5'h07]})
    else $error("steer object range");
  a_steer_idle: assert property (!steer_valid |-> steer_object == 5'h00)
    else $error("idle steer object");

  // ====
  // register bus
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while bvalid");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");

  c_steer: cover property (steer_valid);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == cfd_diag_pkg::RESP_SLVERR);
  c_wdone: cover property (s_axi_bvalid && s_axi_bready);
endmodule : cfd_diag_chk
`default_nettype wire

// file: verification/cfd_bus_model.sv
// bus side model: engine events, bus bit stream and filter hits
`default_nettype none
module cfd_bus_model (
  // clock
  input wire logic sys_clk,
  // engine side
  output var cfd_diag_pkg::cfd_evt_t evt,
  output var cfd_diag_pkg::cfd_crc_t crc,
  output var cfd_diag_pkg::cfd_dlc_t dlc,
  output var cfd_diag_pkg::cfd_bit_t bit_mon,
  output var cfd_diag_pkg::cfd_hit_t hit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    evt = '0;
    crc = '0;
    dlc = '0;
    bit_mon = '0;
    hit = '0;
  end

  // ====
  // pulses; evt is released to zero, other released fields go inverted so a stale value never looks fresh
  task automatic ev(input cfd_diag_pkg::cfd_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask : ev

  task automatic crc_chk(input logic fast, input logic [20:0] calc, input logic [20:0] recv);
    @(posedge sys_clk);
    crc <= {1'b1, fast, calc, recv};
    @(posedge sys_clk);
    crc <= {1'b0, ~fast, ~calc, ~recv};
  endtask : crc_chk

  task automatic dlc_chk(input logic [3:0] code, input logic [2:0] cap);
    @(posedge sys_clk);
    dlc <= {1'b1, code, cap};
    @(posedge sys_clk);
    dlc <= {1'b0, ~code, ~cap};
  endtask : dlc_chk

  // n bus bits at the same levels, one per clock
  task automatic bits(input int n, input logic [7:0] lv);
    @(posedge sys_clk);
    bit_mon <= {1'b1, lv};
    repeat (n) @(posedge sys_clk);
    bit_mon <= {1'b0, ~lv};
  endtask : bits

  task automatic hit_pulse(input logic [1:0] slot);
    @(posedge sys_clk);
    hit <= {1'b1, slot};
    @(posedge sys_clk);
    hit <= {1'b0, ~slot};
  endtask : hit_pulse
endmodule : cfd_bus_model
`default_nettype wire

// file: verification/cfd_diag_tb.sv
// testbench top for the can fd diagnostics block
`default_nettype none
module cfd_diag_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic steer_valid;
  logic [4:0] steer_object;
  cfd_diag_pkg::cfd_evt_t evt;
  cfd_diag_pkg::cfd_crc_t crc;
  cfd_diag_pkg::cfd_dlc_t dlc;
  cfd_diag_pkg::cfd_bit_t bit_mon;
  cfd_diag_pkg::cfd_hit_t hit;
  int fail_count = 0;
  int cmp_count = 0;

  cfd_diag u_cfd_diag (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .evt, .crc, .dlc, .bit_mon, .hit, .steer_valid, .steer_object);
  cfd_bus_model u_cfd_bus_model (.sys_clk, .evt, .crc, .dlc, .bit_mon, .hit);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ====
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("write finished", 32'h1, 32'(s_axi_bvalid));
    chk("write response", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = cfd_diag_pkg::RESP_OKAY);
    int n = 0;
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    s_axi_araddr <= a;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk("read finished", 32'h1, 32'(s_axi_rvalid));
    chk(nm, exp, s_axi_rdata);
    chk("read response", 32'(er), 32'(s_axi_rresp));
  endtask : rc

  // ====
  // scenarios
  task automatic t_regs;
    for (int i = 0; i < 6; i++) rc("reset value", 8'(4 * i), 32'h0);
    rc("unmapped data", 8'h18, 32'h0, cfd_diag_pkg::RESP_SLVERR);
    wr(8'h18, 16'hffff, cfd_diag_pkg::RESP_SLVERR);
    wr(cfd_diag_pkg::OFS_ERR_FLAGS, 16'hffff, cfd_diag_pkg::RESP_OKAY);
    rc("flags written", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h0000dbbf);
    wr(cfd_diag_pkg::OFS_STEER_LOWER, 16'he7e7, cfd_diag_pkg::RESP_OKAY);
    rc("steer lower", cfd_diag_pkg::OFS_STEER_LOWER, 32'h00008787);
    $display("test registers done");
  endtask : t_regs

  // event vectors: 200 fast tx, 100 fast rx, 080 slow tx, 040 slow rx, 001 clean frame
  task automatic t_counts;
    wr(cfd_diag_pkg::OFS_CNT_DATA, 16'hfe10, cfd_diag_pkg::RESP_OKAY);
    u_cfd_bus_model.ev(10'h200);
    u_cfd_bus_model.ev(10'h200);
    u_cfd_bus_model.ev(10'h100);
    rc("data phase counts", cfd_diag_pkg::OFS_CNT_DATA, 32'h0000ff11);
    wr(cfd_diag_pkg::OFS_CNT_NOM, 16'h7f00, cfd_diag_pkg::RESP_OKAY);
    u_cfd_bus_model.ev(10'h080);
    u_cfd_bus_model.ev(10'h040);
    u_cfd_bus_model.ev(10'h040);
    rc("nominal counts", cfd_diag_pkg::OFS_CNT_NOM, 32'h00008002);
    s_axi_wstrb <= 4'h1;
    wr(cfd_diag_pkg::OFS_CLEAN_CNT, 16'hffff, cfd_diag_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    u_cfd_bus_model.ev(10'h001);
    u_cfd_bus_model.ev(10'h001);
    rc("clean count", cfd_diag_pkg::OFS_CLEAN_CNT, 32'h00000101);
    $display("test counters done");
  endtask : t_counts

  task automatic t_flags;
    wr(cfd_diag_pkg::OFS_ERR_FLAGS, 16'h0000, cfd_diag_pkg::RESP_OKAY);
    u_cfd_bus_model.dlc_chk(4'h8, 3'h0);
    u_cfd_bus_model.crc_chk(1'b0, 21'h3, 21'h3);
    rc("flags quiet", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h0);
    u_cfd_bus_model.ev(10'h004);
    u_cfd_bus_model.ev(10'h002);
    u_cfd_bus_model.ev(10'h008);
    u_cfd_bus_model.ev(10'h030);
    u_cfd_bus_model.ev(10'h020);
    u_cfd_bus_model.crc_chk(1'b1, 21'h1, 21'h2);
    u_cfd_bus_model.crc_chk(1'b0, 21'h5, 21'h6);
    u_cfd_bus_model.dlc_chk(4'h9, 3'h0);
    rc("flags raised", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h0000e8ac);
    wr(cfd_diag_pkg::OFS_ERR_FLAGS, 16'h2000, cfd_diag_pkg::RESP_OKAY);
    rc("flags cleared", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h00002000);
    $display("test flags done");
  endtask : t_flags

  // bit levels: fast, tx_active, tx_level, bus_level, arbitration, stuff, drive, recovering
  task automatic t_bits;
    wr(cfd_diag_pkg::OFS_ERR_FLAGS, 16'h0000, cfd_diag_pkg::RESP_OKAY);
    u_cfd_bus_model.bits(5, 8'b0000_0100);
    u_cfd_bus_model.bits(1, 8'b0110_1000);
    rc("five equal bits", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h0);
    u_cfd_bus_model.bits(6, 8'b0000_0100);
    u_cfd_bus_model.bits(1, 8'b1110_0000);
    u_cfd_bus_model.bits(1, 8'b0110_0000);
    u_cfd_bus_model.bits(1, 8'b1101_0010);
    u_cfd_bus_model.bits(1, 8'b0101_0010);
    rc("bit faults", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h00000313);
    wr(cfd_diag_pkg::OFS_ERR_FLAGS, 16'h0000, cfd_diag_pkg::RESP_OKAY);
    u_cfd_bus_model.bits(10, 8'b0001_0001);
    rc("ten recessive", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h0);
    u_cfd_bus_model.bits(1, 8'b0001_0001);
    rc("eleven recessive", cfd_diag_pkg::OFS_ERR_FLAGS, 32'h00000001);
    $display("test bit monitor done");
  endtask : t_bits

  task automatic t_steer;
    logic [4:0] exp_o[4];
    exp_o = '{5'h01, 5'h00, 5'h07, 5'h00};
    wr(cfd_diag_pkg::OFS_STEER_LOWER, 16'h0781, cfd_diag_pkg::RESP_OKAY);
    wr(cfd_diag_pkg::OFS_STEER_UPPER, 16'h8087, cfd_diag_pkg::RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      u_cfd_bus_model.hit_pulse(2'(s));
      #1;
      chk("steer valid", 32'(exp_o[s] != 5'h00), 32'(steer_valid));
      chk("steer object", 32'(exp_o[s]), 32'(steer_object));
    end
    $display("test steering done");
  endtask : t_steer

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    rst_b <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_regs();
    t_counts();
    t_flags();
    t_bits();
    t_steer();
    end_of_test();
  end

  // run needs under 2000 cycles
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
endmodule : cfd_diag_tb

bind cfd_diag cfd_diag_chk u_cfd_diag_chk (.sys_clk, .rst_b, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .hit, .steer_valid, .steer_object);
`default_nettype wire
